// >>> logic/sbp_pkg.sv
// register map, field layout, reset values and types of the phy base register bank
`default_nettype none
package sbp_pkg;
    // apb address width and register indices (byte address is four times the index)
    localparam int SBP_ADDR_W = 8;
    localparam logic [4:0] SBP_IDX_NODE = 5'h00;
    localparam logic [4:0] SBP_IDX_CTRL_GAP = 5'h01;
    localparam logic [4:0] SBP_IDX_EXT_PORTS = 5'h02;
    localparam logic [4:0] SBP_IDX_SPEED_DLY = 5'h03;
    localparam logic [4:0] SBP_IDX_LINK_PWR = 5'h04;
    localparam logic [4:0] SBP_IDX_INT_FEAT = 5'h05;
    localparam logic [4:0] SBP_IDX_RSVD_SIX = 5'h06;
    localparam logic [4:0] SBP_IDX_PAGE_SEL = 5'h07;
    localparam logic [4:0] SBP_IDX_PAGED_LO = 5'h08;
    localparam logic [4:0] SBP_IDX_PAGED_HI = 5'h0F;
    localparam logic [4:0] SBP_IDX_IRQ_STAT = 5'h10;
    localparam logic [4:0] SBP_IDX_IRQ_MASK = 5'h11;
    // constant capability fields
    localparam logic [2:0] SBP_EXT_VAL = 3'h7;
    localparam logic [3:0] SBP_PORTS_VAL = 4'h3;
    localparam logic [2:0] SBP_SPEED_VAL = 3'h2;
    localparam logic [3:0] SBP_DELAY_VAL = 4'h0;
    localparam logic [2:0] SBP_JITTER_VAL = 3'h0;
    // values after hardware reset
    localparam logic [5:0] SBP_GAP_RST = 6'h3F;
    localparam logic SBP_LCTRL_RST = 1'b1;
    // pages that hold storage; pages 2..6 are reserved
    localparam logic [2:0] SBP_PAGE_RSVD_LO = 3'h2;
    localparam logic [2:0] SBP_PAGE_RSVD_HI = 3'h6;
    localparam logic [1:0] SBP_SLOT_PAGE7 = 2'h2;
    // interrupt status bit positions
    localparam int SBP_IRQ_W = 4;
    localparam int SBP_IRQ_SELFID = 0;
    localparam int SBP_IRQ_ROOT = 1;
    localparam int SBP_IRQ_CPWR = 2;
    localparam int SBP_IRQ_BUSRST = 3;
    // long bus reset timing
    localparam int SBP_CLK_MHZ = 100;
    localparam int SBP_LONG_RESET_US = 166;
    localparam int SBP_LONG_RESET_CYC = SBP_LONG_RESET_US * SBP_CLK_MHZ;
    localparam int SBP_LR_CNT_W = 16;

    // long reset sequencer states
    typedef enum logic [2:0] {
        SBP_LR_IDLE = 3'b001,
        SBP_LR_WAIT = 3'b010,
        SBP_LR_DRIVE = 3'b100
    } sbp_lr_state_t;

    // events reported by the phy core
    typedef struct packed {
        logic [5:0] node_addr;
        logic selfid_done;
        logic root_won;
        logic bus_reset;
        logic gap_valid;
        logic [5:0] gap_value;
        logic xfer_busy;
    } sbp_phy_evt_t;

    // whole state of the register bank
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [5:0] node_addr;
        logic node_valid;
        logic root;
        logic cable_pwr;
        logic root_holdoff_bit;
        logic long_bus_reset_request;
        logic [5:0] gap;
        logic gap_armed;
        logic lctrl;
        logic contender;
        logic [2:0] pwr_class;
        logic [7:0] feat;
        logic [2:0] page;
        logic [3:0] port;
        logic [2:0][7:0][7:0] paged;
        logic [SBP_IRQ_W-1:0] irq_stat;
        logic [SBP_IRQ_W-1:0] irq_mask;
        logic irq;
        sbp_lr_state_t lr_state;
        logic [SBP_LR_CNT_W-1:0] lr_cnt;
        logic long_reset;
        logic status_xfer;
    } sbp_state_t;
endpackage : sbp_pkg
`default_nettype wire

// >>> logic/sbp_phy_regs.sv
// apb register bank of a three-port serial bus phy: base and paged registers
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none

// What this block does
// - Eighteen registers are kept: eight fixed base ones, eight paged ones chosen by the page, interrupt status and mask.
// - The page selector lives in base register 7 and never changes the meaning of base fields.
// - Reserved registers and fields read zero, and every register of pages 2 to 6 is reserved.
// - The read-only node address is loaded at self-id and announced by a register-0 status pulse.
// - The read-only root flag clears on every bus reset and sets when this node wins root.
// - The read-only cable power flag mirrors the cable power sense input.
// - Root holdoff is writable, cleared by hardware reset and kept across bus resets.
// - Setting the initiate bit starts a long 166 us bus reset at the next chance.
// - A transfer in progress is finished before the requested bus reset starts.
// - The initiate bit clears after hardware reset and after any bus reset.
// - The writable 6-bit gap count drives the arbitration gap timing.
// - The gap count updates on a register write or on a received or sent config packet.
// - The gap count returns to 3Fh on hardware reset or after two bus resets with no update.
// - Capability fields read fixed: extended 111b, three ports, speed 010b.
module sbp_phy_regs #(
    parameter int LONG_RESET_CYCLES = sbp_pkg::SBP_LONG_RESET_CYC
) (
    // clock and synchronous reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // apb slave
    input wire logic APB_PSEL_I,
    input wire logic APB_PENABLE_I,
    input wire logic APB_PWRITE_I,
    input wire logic [sbp_pkg::SBP_ADDR_W-1:0] APB_PADDR_I,
    input wire logic [31:0] APB_PWDATA_I,
    output logic [31:0] APB_PRDATA_O,
    output logic APB_PREADY_O,
    output logic APB_PSLVERR_O,
    // phy core events and sense inputs
    input wire sbp_pkg::sbp_phy_evt_t PHY_EVT_I,
    input wire logic CABLE_POWER_I,
    input wire logic CONTENDER_STRAP_I,
    input wire logic [2:0] POWER_CLASS_STRAP_I,
    // controls towards the phy core
    output logic LONG_RESET_O,
    output logic STATUS_XFER_O,
    output logic ROOT_HOLDOFF_O,
    output logic [5:0] GAP_COUNT_O,
    output logic LINK_ACTIVE_O,
    output logic CONTENDER_O,
    output logic [2:0] POWER_CLASS_O,
    // interrupt
    output logic IRQ_O
);
    import sbp_pkg::*;

    sbp_state_t s_r;
    sbp_state_t s_nxt;
    sbp_state_t rst_val;

    logic [4:0] idx;
    logic addr_ok;
    logic wr_done;
    logic gap_upd;
    logic bus_reset;
    logic [7:0] wbyte;
    logic [SBP_IRQ_W-1:0] evt;

    // page to storage slot: pages 0 and 1 keep slots 0 and 1, page 7 slot 2
    function automatic logic [2:0] page_slot(input logic [2:0] page);
        logic [2:0] res;
        res = 3'h0;
        if (page == 3'h7) begin
            res = {1'b1, SBP_SLOT_PAGE7};
        end else if (page < SBP_PAGE_RSVD_LO) begin
            res = {1'b1, 1'b0, page[0]};
        end
        return res;
    endfunction : page_slot

    // read multiplexer over the whole map
    function automatic logic [31:0] read_reg(input sbp_state_t st, input logic [4:0] ri);
        logic [31:0] res;
        logic [2:0] slot;
        res = 32'h0;
        slot = page_slot(st.page);
        case (ri)
            SBP_IDX_NODE: begin
                res[7:0] = {st.node_addr, st.root, st.cable_pwr};
            end
            SBP_IDX_CTRL_GAP: begin
                res[7:0] = {st.root_holdoff_bit, st.long_bus_reset_request, st.gap};
            end
            SBP_IDX_EXT_PORTS: begin
                res[7:0] = {SBP_EXT_VAL, 1'b0, SBP_PORTS_VAL};
            end
            SBP_IDX_SPEED_DLY: begin
                res[7:0] = {SBP_SPEED_VAL, 1'b0, SBP_DELAY_VAL};
            end
            SBP_IDX_LINK_PWR: begin
                res[7:0] = {st.lctrl, st.contender, SBP_JITTER_VAL, st.pwr_class};
            end
            SBP_IDX_INT_FEAT: begin
                res[7:0] = st.feat;
            end
            SBP_IDX_PAGE_SEL: begin
                res[7:0] = {st.page, 1'b0, st.port};
            end
            SBP_IDX_IRQ_STAT: begin
                res[SBP_IRQ_W-1:0] = st.irq_stat;
            end
            SBP_IDX_IRQ_MASK: begin
                res[SBP_IRQ_W-1:0] = st.irq_mask;
            end
            default: begin
                // paged window; reserved pages and register six read zero
                if (ri >= SBP_IDX_PAGED_LO && ri <= SBP_IDX_PAGED_HI && slot[2]) begin
                    res[7:0] = st.paged[slot[1:0]][ri[2:0]];
                end
            end
        endcase
        return res;
    endfunction : read_reg

    // values after hardware reset; straps are taken while reset is held
    always_comb begin
        rst_val = '0;
        rst_val.lr_state = SBP_LR_IDLE;
        rst_val.gap = SBP_GAP_RST;
        rst_val.lctrl = SBP_LCTRL_RST;
        rst_val.contender = CONTENDER_STRAP_I;
        rst_val.pwr_class = POWER_CLASS_STRAP_I;
        rst_val.cable_pwr = CABLE_POWER_I;
    end

    // address decode: word aligned, index at most the mask register
    always_comb begin
        idx = APB_PADDR_I[6:2];
        addr_ok = (APB_PADDR_I[1:0] == 2'h0)
            && ((APB_PADDR_I >> 7) == '0)
            && (idx <= SBP_IDX_IRQ_MASK);
        wr_done = APB_PSEL_I && APB_PENABLE_I && s_r.pready && APB_PWRITE_I && addr_ok;
        wbyte = APB_PWDATA_I[7:0];
    end

    // next state of the whole bank
    always_comb begin
        s_nxt = s_r;
        s_nxt.status_xfer = 1'b0;
        gap_upd = 1'b0;
        bus_reset = PHY_EVT_I.bus_reset;
        evt = '0;

        // apb answer: one wait state, data and error sampled with ready
        s_nxt.pready = APB_PSEL_I && APB_PENABLE_I && !s_r.pready;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = 32'h0;
        if (APB_PSEL_I && APB_PENABLE_I && !s_r.pready) begin
            s_nxt.pslverr = !addr_ok;
            if (addr_ok && !APB_PWRITE_I) begin
                s_nxt.prdata = read_reg(s_r, idx);
            end
        end

        // register writes; read-only indices simply fall through
        // addressed writes only
        if (wr_done) begin
            case (idx)
                SBP_IDX_CTRL_GAP: begin
                    s_nxt.root_holdoff_bit = wbyte[7];
                    s_nxt.long_bus_reset_request = wbyte[6];
                    s_nxt.gap = wbyte[5:0];
                    gap_upd = 1'b1;
                end
                SBP_IDX_LINK_PWR: begin
                    s_nxt.lctrl = wbyte[7];
                    s_nxt.contender = wbyte[6];
                    s_nxt.pwr_class = wbyte[2:0];
                end
                SBP_IDX_INT_FEAT: begin
                    s_nxt.feat = wbyte;
                end
                SBP_IDX_PAGE_SEL: begin
                    s_nxt.page = wbyte[7:5];
                    s_nxt.port = wbyte[3:0];
                end
                SBP_IDX_IRQ_STAT: begin
                    s_nxt.irq_stat = s_r.irq_stat & ~APB_PWDATA_I[SBP_IRQ_W-1:0];
                end
                SBP_IDX_IRQ_MASK: begin
                    s_nxt.irq_mask = APB_PWDATA_I[SBP_IRQ_W-1:0];
                end
                default: begin
                    if (idx >= SBP_IDX_PAGED_LO && page_slot(s_r.page) != 3'h0) begin
                        s_nxt.paged[2'(page_slot(s_r.page))][idx[2:0]] = wbyte;
                    end
                end
            endcase
        end

        // gap by config packet, overrides a write in the same cycle
        if (PHY_EVT_I.gap_valid) begin
            s_nxt.gap = PHY_EVT_I.gap_value;
            gap_upd = 1'b1;
        end

        // long reset sequencer; waits out a running transfer first
        s_nxt.long_reset = 1'b0;
        case (s_r.lr_state)
            SBP_LR_IDLE: begin
                if (s_r.long_bus_reset_request) begin
                    if (PHY_EVT_I.xfer_busy || PHY_EVT_I.bus_reset) begin
                        s_nxt.lr_state = PHY_EVT_I.bus_reset ? SBP_LR_IDLE : SBP_LR_WAIT;
                    end else begin
                        s_nxt.lr_state = SBP_LR_DRIVE;
                        s_nxt.lr_cnt = SBP_LR_CNT_W'(LONG_RESET_CYCLES - 1);
                        s_nxt.long_reset = 1'b1;
                        bus_reset = 1'b1;
                    end
                end
            end
            SBP_LR_WAIT: begin
                if (PHY_EVT_I.bus_reset) begin
                    // a reset from elsewhere already served the request
                    s_nxt.lr_state = SBP_LR_IDLE;
                end else if (!PHY_EVT_I.xfer_busy) begin
                    s_nxt.lr_state = SBP_LR_DRIVE;
                    s_nxt.lr_cnt = SBP_LR_CNT_W'(LONG_RESET_CYCLES - 1);
                    s_nxt.long_reset = 1'b1;
                    bus_reset = 1'b1;
                end
            end
            SBP_LR_DRIVE: begin
                // hold for the long reset time
                if (s_r.lr_cnt == '0) begin
                    s_nxt.lr_state = SBP_LR_IDLE;
                end else begin
                    s_nxt.lr_cnt = s_r.lr_cnt - 1'b1;
                    s_nxt.long_reset = 1'b1;
                end
            end
            default: begin
                s_nxt.lr_state = SBP_LR_IDLE;
            end
        endcase

        // bus reset effects; root holdoff is deliberately left alone
        if (bus_reset) begin
            evt[SBP_IRQ_BUSRST] = 1'b1;
            s_nxt.root = 1'b0;
            s_nxt.long_bus_reset_request = 1'b0;
            s_nxt.node_valid = 1'b0;
            if (s_r.gap_armed && !gap_upd) begin
                s_nxt.gap = SBP_GAP_RST;
            end
            s_nxt.gap_armed = 1'b1;
        end else if (gap_upd) begin
            s_nxt.gap_armed = 1'b0;
        end

        // self-id loads address and reports register 0
        if (PHY_EVT_I.selfid_done) begin
            s_nxt.node_addr = PHY_EVT_I.node_addr;
            s_nxt.node_valid = 1'b1;
            s_nxt.status_xfer = 1'b1;
            evt[SBP_IRQ_SELFID] = 1'b1;
        end

        if (PHY_EVT_I.root_won) begin
            s_nxt.root = 1'b1;
            evt[SBP_IRQ_ROOT] = 1'b1;
        end

        // cable power mirror; a fall raises an event
        s_nxt.cable_pwr = CABLE_POWER_I;
        if (s_r.cable_pwr && !CABLE_POWER_I) begin
            evt[SBP_IRQ_CPWR] = 1'b1;
        end

        // events set after the clear so a coincident event is not lost
        s_nxt.irq_stat = s_nxt.irq_stat | evt;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    // one register for the whole bank
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            s_r <= rst_val;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign APB_PRDATA_O = s_r.prdata;
    assign APB_PREADY_O = s_r.pready;
    assign APB_PSLVERR_O = s_r.pslverr;
    assign LONG_RESET_O = s_r.long_reset;
    assign STATUS_XFER_O = s_r.status_xfer;
    assign ROOT_HOLDOFF_O = s_r.root_holdoff_bit;
    // gap count to the arbitration timers
    assign GAP_COUNT_O = s_r.gap;
    assign LINK_ACTIVE_O = s_r.lctrl;
    assign CONTENDER_O = s_r.contender;
    assign POWER_CLASS_O = s_r.pwr_class;
    assign IRQ_O = s_r.irq;
endmodule : sbp_phy_regs
`default_nettype wire

// >>> dv/sbp_phy_regs_properties.sv
// assertions on the ports of the phy base register bank
`default_nettype none
module sbp_phy_regs_properties import sbp_pkg::*; #(
    parameter int LONG_RESET_CYCLES = 8
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // apb
    input wire logic APB_PSEL_I,
    input wire logic APB_PENABLE_I,
    input wire logic APB_PWRITE_I,
    input wire logic [sbp_pkg::SBP_ADDR_W-1:0] APB_PADDR_I,
    input wire logic [31:0] APB_PWDATA_I,
    input wire logic [31:0] APB_PRDATA_O,
    input wire logic APB_PREADY_O,
    input wire logic APB_PSLVERR_O,
    // phy side
    input wire sbp_pkg::sbp_phy_evt_t PHY_EVT_I,
    input wire logic CABLE_POWER_I,
    input wire logic CONTENDER_STRAP_I,
    input wire logic [2:0] POWER_CLASS_STRAP_I,
    input wire logic LONG_RESET_O,
    input wire logic STATUS_XFER_O,
    input wire logic ROOT_HOLDOFF_O,
    input wire logic [5:0] GAP_COUNT_O,
    input wire logic LINK_ACTIVE_O,
    input wire logic CONTENDER_O,
    input wire logic [2:0] POWER_CLASS_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_gap;
    logic [15:0] lr_len_r;
    // completing write to the control and gap register
    assign wr_gap = APB_PSEL_I && APB_PENABLE_I && APB_PREADY_O && APB_PWRITE_I
        && APB_PADDR_I == 8'h04;
    // counts cycles of the long reset; a plain repetition would not scale with the parameter
    always_ff @(posedge MCLK_I) begin
        if (RST_I || !LONG_RESET_O) lr_len_r <= 16'h0000;
        else lr_len_r <= lr_len_r + 16'h0001;
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    one_wait_a: assert property ((APB_PSEL_I && !APB_PENABLE_I) ##1 (APB_PSEL_I && APB_PENABLE_I)
        |-> !APB_PREADY_O ##1 APB_PREADY_O) else $error("ready not after one wait state");
    ready_pulse_a: assert property (APB_PREADY_O |=> !APB_PREADY_O) else $error("ready too long");
    rdata_idle_a: assert property (!APB_PREADY_O |-> APB_PRDATA_O == 32'h0)
        else $error("read data outside answer");
    upper_zero_a: assert property (APB_PRDATA_O[31:8] == 24'h0)
        else $error("unused read bits not zero");
    reset_len_a: assert property ($fell(LONG_RESET_O) |-> lr_len_r == LONG_RESET_CYCLES)
        else $error("long reset length wrong");
    reset_cap_a: assert property (lr_len_r <= LONG_RESET_CYCLES)
        else $error("long reset too long");
    busy_defer_a: assert property ($rose(LONG_RESET_O) |-> !$past(PHY_EVT_I.xfer_busy))
        else $error("long reset began during transfer");
    status_pulse_a: assert property (PHY_EVT_I.selfid_done |=> STATUS_XFER_O)
        else $error("no status transfer after self-id");
    status_cause_a: assert property (STATUS_XFER_O |-> $past(PHY_EVT_I.selfid_done))
        else $error("status transfer without self-id");
    gap_event_a: assert property (PHY_EVT_I.gap_valid |=> GAP_COUNT_O == $past(PHY_EVT_I.gap_value))
        else $error("gap count not taken from packet");
    gap_write_a: assert property (wr_gap && !PHY_EVT_I.gap_valid |=>
        GAP_COUNT_O == $past(APB_PWDATA_I[5:0]) && ROOT_HOLDOFF_O == $past(APB_PWDATA_I[7]))
        else $error("gap register write lost");
    holdoff_keep_a: assert property (PHY_EVT_I.bus_reset && !wr_gap |=> $stable(ROOT_HOLDOFF_O))
        else $error("root holdoff changed by bus reset");
    // main scenarios reached
    cover property ($rose(LONG_RESET_O));
    cover property (wr_gap);
    cover property (APB_PREADY_O && APB_PSLVERR_O);
    cover property ($rose(IRQ_O));
endmodule : sbp_phy_regs_properties
`default_nettype wire

// >>> dv/sbp_link_model.sv
// link controller model: apb master reading and writing the phy registers
`default_nettype none
module sbp_link_model import sbp_pkg::*; (
    // clock
    input wire logic clk_i,
    // apb request
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [sbp_pkg::SBP_ADDR_W-1:0] paddr_o,
    output logic [31:0] pwdata_o,
    // apb answer
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus from time zero
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // one transfer; the wait is bounded so a silent slave cannot hang the run
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic ok);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 20);
        ok = (pready_i === 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // released data no longer shows the old value
        pwdata_o <= ~d;
    endtask : xfer
endmodule : sbp_link_model
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the phy base register bank
`default_nettype none
module testbench import sbp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LR_CYC = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, lr, irq, q_e, ok;
    logic [SBP_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q, v;
    sbp_phy_evt_t evt = '0;
    logic cpwr = 1'b1;
    logic con_s = 1'b0;
    logic [2:0] pc_s = 3'h0;
    logic [7:0] mem [0:7][0:7];
    logic [7:0] ro_a [0:2] = '{8'h08, 8'h0C, 8'h18};
    logic [7:0] ro_v [0:2] = '{8'hE3, 8'h40, 8'h00};
    int n_errors = 0;
    int tests_run = 0;
    int seed = 23;
    // 100 MHz clock
    always #5 clk = ~clk;
    sbp_phy_regs #(.LONG_RESET_CYCLES(LR_CYC)) sbp_phy_regs_i (
        .MCLK_I(clk), .RST_I(rst), .APB_PSEL_I(psel), .APB_PENABLE_I(penable),
        .APB_PWRITE_I(pwrite), .APB_PADDR_I(paddr), .APB_PWDATA_I(pwdata),
        .APB_PRDATA_O(prdata), .APB_PREADY_O(pready), .APB_PSLVERR_O(pslverr),
        .PHY_EVT_I(evt), .CABLE_POWER_I(cpwr), .CONTENDER_STRAP_I(con_s),
        .POWER_CLASS_STRAP_I(pc_s), .LONG_RESET_O(lr), .STATUS_XFER_O(), .ROOT_HOLDOFF_O(),
        .GAP_COUNT_O(), .LINK_ACTIVE_O(), .CONTENDER_O(), .POWER_CLASS_O(), .IRQ_O(irq));
    sbp_link_model sbp_link_model_i (
        .clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
    task automatic close_out();
        if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
        sbp_link_model_i.xfer(w, a, d, q, q_e, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t no ready", $time);
            close_out();
        end
    endtask : io
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        io(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // one-cycle phy pulses: self-id, root won, bus reset, gap packet
    task automatic ev(input logic [3:0] p, input logic [5:0] gv);
        @(posedge clk);
        {evt.selfid_done, evt.root_won, evt.bus_reset, evt.gap_valid} <= p;
        evt.gap_value <= gv;
        @(posedge clk);
        {evt.selfid_done, evt.root_won, evt.bus_reset, evt.gap_valid} <= 4'h0;
    endtask : ev
    // main sequence
    initial begin
        int n;
        con_s = 1'($random(seed));
        pc_s = 3'($random(seed));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(8'h04, 32'h3F);
        rd(8'h10, {24'h0, 1'b1, con_s, 3'h0, pc_s});
        for (int i = 0; i < 3; i++) begin
            rd(ro_a[i], {24'h0, ro_v[i]});
            io(1'b1, ro_a[i], $random(seed));
            rd(ro_a[i], {24'h0, ro_v[i]});
        end
        // fill every page, then read back; reserved pages keep nothing
        for (int p = 0; p < 16; p++) begin
            v = $random(seed);
            v[7:5] = 3'(p);
            io(1'b1, 8'h1C, v);
            rd(8'h1C, {24'h0, v[7:5], 1'b0, v[3:0]});
            for (int k = 0; k < 8; k++) begin
                if (p < 8) mem[p][k] = 8'($random(seed));
                if (p < 8) io(1'b1, 8'(8'h20 + 4 * k), {24'h0, mem[p][k]});
                else rd(8'(8'h20 + 4 * k), (p % 8 inside {[2:6]}) ? 32'h0 : {24'h0, mem[p % 8][k]});
            end
            rd(8'h04, 32'h3F);
        end
        // self-id, root, cable power and interrupts
        io(1'b1, 8'h44, 32'h1);
        v = $random(seed);
        evt.node_addr <= v[5:0];
        ev(4'b1100, 6'h00);
        rd(8'h00, {24'h0, v[5:0], 2'b11});
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        rd(8'h40, 32'h3);
        io(1'b1, 8'h40, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        cpwr <= 1'b0;
        ev(4'b0010, 6'h00);
        rd(8'h00, {24'h0, v[5:0], 2'b00});
        rd(8'h40, 32'hE);
        // gap count: write, then two bus resets without update
        v = $random(seed);
        io(1'b1, 8'h04, {24'h0, 2'b10, v[5:0]});
        rd(8'h04, {24'h0, 2'b10, v[5:0]});
        ev(4'b0010, 6'h00);
        rd(8'h04, {24'h0, 2'b10, v[5:0]});
        ev(4'b0010, 6'h00);
        rd(8'h04, 32'hBF);
        ev(4'b0001, 6'h21);
        ev(4'b0010, 6'h00);
        rd(8'h04, 32'hA1);
        // long bus reset held off by a transfer in progress
        evt.xfer_busy <= 1'b1;
        io(1'b1, 8'h04, 32'h61);
        repeat (20) begin
            @(negedge clk);
            chk({31'h0, lr}, 32'h0);
        end
        @(posedge clk);
        evt.xfer_busy <= 1'b0;
        n = 0;
        while (lr !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, lr}, 32'h1);
        while (lr === 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, lr}, 32'h0);
        rd(8'h04, 32'h21);
        // unmapped and misaligned addresses are refused
        rd(8'h48, 32'h0);
        chk({31'h0, q_e}, 32'h1);
        rd(8'h05, 32'h0);
        chk({31'h0, q_e}, 32'h1);
        close_out();
    end
endmodule : testbench
bind sbp_phy_regs sbp_phy_regs_properties #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) props_i (.*);
`default_nettype wire
